// *** shared/dss_params.svh ***
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

// System clocks that make one converter count; two lets a strobe be half a count.
`define DSS_CLKS_PER_COUNT 2
// Counts from input-accumulate start to the next cycle start in free-run.
`define DSS_CYCLE_CNT 40002
// Fixed input-accumulate length in counts.
`define DSS_ACCUM_CNT 10000
// Largest reading that is still in range.
`define DSS_FULL_SCALE_CNT 20000
// Integrator-reset length after a normal and after an overrange conversion.
`define DSS_ZI_NORMAL_CNT 100
`define DSS_ZI_OVER_CNT 6200
// Offset-null length after a run/hold start pulse, in counts.
`define DSS_START_AZ_CNT 2
// Readings at or below this raise the underrange flag.
`define DSS_UNDER_CNT 1800
// Digit drive lengths and strobe position within a digit, in counts.
`define DSS_TOP_DIGIT_CNT 201
`define DSS_DIGIT_CNT 200
`define DSS_STROBE_POS 100
// Reset values.
`define DSS_RST_DRIVE 5'h00
`define DSS_RST_BCD 4'h0

`endif

// *** shared/dss_pkg.sv ***
package dss_pkg;

    // Measurement phases, one-hot.
    typedef enum logic [3:0] {
        DSS_OFFSET_NULL = 4'b0001,
        DSS_ACCUM = 4'b0010,
        DSS_DISCHARGE = 4'b0100,
        DSS_INT_RESET = 4'b1000
    } dss_phase_t;

    // Analogue switch controls driven by the sequencer.
    typedef struct packed {
        logic short_to_common;
        logic ref_cap_charge;
        logic offset_loop;
        logic inputs_to_pins;
        logic ref_cap_connect;
        logic ref_cap_invert;
        logic low_to_common;
        logic reset_loop;
    } dss_switch_t;

    // Five BCD digits, index 4 is the top digit.
    typedef logic [4:0][3:0] dss_digits_t;

    // Increments a five-digit BCD count by one.
    function automatic dss_digits_t dss_bcd_inc(input dss_digits_t v);
        dss_digits_t r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < 5; i++) begin
            if (carry) begin
                if (r[i] == 4'h9) begin
                    r[i] = 4'h0;
                end else begin
                    r[i] = r[i] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
        return r;
    endfunction

endpackage

// *** design/dss_digit_scan.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dss_params.svh"

module dss_digit_scan (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic restart_i,
    input wire logic resume_i,
    input wire logic over_i,
    input wire dss_pkg::dss_digits_t digits_i,
    output logic [4:0] drive_o,
    output logic [3:0] bcd_o,
    output logic strobe_n_o
);
    import dss_pkg::*;

    logic [2:0] dig_q;
    logic [7:0] dcnt_q;
    logic [7:0] len_q;
    logic armed_q;
    logic blank_q;
    logic wrap;

    assign wrap = tick_i && (dcnt_q == len_q - 8'h01);

    // Digit position and count within it; a new result restarts at the top.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dig_q <= 3'h0;
            dcnt_q <= 8'h00;
            len_q <= 8'(`DSS_DIGIT_CNT);
        end else if (restart_i) begin
            dig_q <= 3'h0; // RULE15
            dcnt_q <= 8'h00;
            len_q <= 8'(`DSS_TOP_DIGIT_CNT); // RULE15
        end else if (resume_i && blank_q) begin
            dig_q <= 3'h0; // RULE22
            dcnt_q <= 8'h00;
            len_q <= 8'(`DSS_DIGIT_CNT);
        end else if (wrap) begin
            dig_q <= (dig_q == 3'h4) ? 3'h0 : dig_q + 3'h1; // RULE18 RULE22
            dcnt_q <= 8'h00;
            len_q <= 8'(`DSS_DIGIT_CNT); // RULE17
        end else if (tick_i) begin
            dcnt_q <= dcnt_q + 8'h01;
        end
    end

    // Strobes are armed once per result and blanking follows an overrange.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            armed_q <= 1'b0;
            blank_q <= 1'b0;
        end else if (restart_i) begin
            armed_q <= 1'b1; // RULE14
            blank_q <= 1'b0;
        end else if (resume_i && blank_q) begin
            blank_q <= 1'b0; // RULE22
        end else if (wrap && dig_q == 3'h4 && armed_q) begin
            armed_q <= 1'b0; // RULE14
            blank_q <= over_i; // RULE22
        end
    end

    // Registered pins; the strobe is low for the second half of count 100.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            drive_o <= `DSS_RST_DRIVE;
            bcd_o <= `DSS_RST_BCD;
            strobe_n_o <= 1'b1;
        end else begin
            drive_o <= blank_q ? 5'h00 : (5'h10 >> dig_q); // RULE22
            bcd_o <= digits_i[3'h4 - dig_q]; // RULE24
            strobe_n_o <= ~(armed_q && !tick_i &&
                            dcnt_q == 8'(`DSS_STROBE_POS)); // RULE16 RULE17
        end
    end

endmodule // dss_digit_scan

`default_nettype wire

// *** design/dss_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dss_params.svh"

// Contract
// RULE1: Each cycle runs offset-null, accumulate, discharge, integrator-reset in order.
// RULE2: Offset-null shorts inputs to common, charges reference, closes offset loop.
// RULE3: Accumulate opens offset loop, connects pins, integrates for fixed time.
// RULE4: Integrated sign is latched at accumulate end and reported as polarity.
// RULE5: Discharge connects reference against sign, counts clocks to zero crossing.
// RULE6: Integrator-reset shorts low input to common, closes loop to high input.
// RULE7: Integrator-reset lasts 100 to 200 counts, 6200 after overrange.
// RULE8: Run/hold high gives free-running cycles every 40,002 counts.
// RULE9: Run/hold low finishes current cycle then holds the reading.
// RULE10: Controller starts single conversion with run/hold pulse over 300ns.
// RULE11: Pulse-started conversion begins with 1 to 10,001 counts of offset-null.
// RULE12: A run/hold pulse before the cycle completes is ignored.
// RULE13: Controller treats converter as held after run/hold low 101 counts.
// RULE14: Exactly five low strobes per result, first 101 counts after end.
// RULE15: Top digit drive rises at measurement end, lasts 201 counts.
// RULE16: Each strobe is low half a count, centred within its digit.
// RULE17: Next digits last 200 counts, strobe 100 counts after drive rises.
// RULE18: Drive and strobe pattern continues to bottom digit, fifth strobe.
// RULE19: Busy from accumulate start to clock after zero crossing; results load next.
// RULE20: Overrange set at busy end above 20,000, cleared at next discharge.
// RULE21: Underrange set at busy end at 1800 or less, cleared at accumulate.
// RULE22: Digits scan continuously, blanked after strobes on overrange until discharge.
// RULE23: Full-scale count without crossing declares overrange, ends discharge.
// RULE24: BCD outputs show the active digit, changing only at digit boundaries.
module dss_sequencer #(
    parameter int CYCLE_CNT = `DSS_CYCLE_CNT,
    parameter int ACCUM_CNT = `DSS_ACCUM_CNT,
    parameter int FULL_SCALE_CNT = `DSS_FULL_SCALE_CNT,
    parameter int ZI_OVER_CNT = `DSS_ZI_OVER_CNT
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_hold_i,
    input wire logic comp_positive_i,
    output dss_pkg::dss_switch_t switch_o,
    output dss_pkg::dss_phase_t phase_o,
    output logic busy_o,
    output logic polarity_o,
    output logic overrange_o,
    output logic underrange_o,
    output logic [4:0] digit_drive_o,
    output logic [3:0] bcd_o,
    output logic strobe_n_o
);
    import dss_pkg::*;

    dss_phase_t phase_q;
    logic [$clog2(`DSS_CLKS_PER_COUNT)-1:0] div_q;
    logic tick;
    logic [15:0] cyc_q;
    logic [15:0] ph_cnt_q;
    logic [15:0] disch_q;
    dss_digits_t bcd_cnt_q;
    dss_digits_t result_q;
    logic done_q;
    logic start_req_q;
    logic pol_q;
    logic over_cycle_q;
    logic load_q;
    logic meas_end_q;
    logic de_start_q;
    logic crossing;
    logic full;
    logic [15:0] zi_len;

    // Divides the system clock into converter counts.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign tick = (div_q == ($clog2(`DSS_CLKS_PER_COUNT))'(`DSS_CLKS_PER_COUNT - 1));

    // The comparator has crossed zero once its sign differs from the latched one.
    assign crossing = (comp_positive_i != pol_q); // RULE5
    assign full = (disch_q == 16'(FULL_SCALE_CNT)); // RULE23
    assign zi_len = over_cycle_q ? 16'(ZI_OVER_CNT)
                                 : 16'(`DSS_ZI_NORMAL_CNT); // RULE7

    // Start requests are only taken once the cycle is complete.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            start_req_q <= 1'b0;
        end else if (phase_q == DSS_ACCUM) begin
            start_req_q <= 1'b0;
        end else if (done_q && run_hold_i) begin
            start_req_q <= 1'b1; // RULE12
        end
    end

    // Phase sequencer, stepping once per count.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            phase_q <= DSS_OFFSET_NULL;
            ph_cnt_q <= 16'h0000;
            done_q <= 1'b1;
        end else if (tick) begin
            case (phase_q)
                DSS_OFFSET_NULL: begin
                    if (!done_q && cyc_q == 16'(CYCLE_CNT - 1)) begin
                        if (run_hold_i) begin
                            phase_q <= DSS_ACCUM; // RULE8
                            ph_cnt_q <= 16'h0000;
                        end else begin
                            done_q <= 1'b1; // RULE9
                            ph_cnt_q <= 16'h0000;
                        end
                    end else if (done_q && start_req_q) begin
                        if (ph_cnt_q == 16'(`DSS_START_AZ_CNT - 1)) begin
                            phase_q <= DSS_ACCUM; // RULE11
                            ph_cnt_q <= 16'h0000;
                            done_q <= 1'b0;
                        end else begin
                            ph_cnt_q <= ph_cnt_q + 16'h0001;
                        end
                    end
                end
                DSS_ACCUM: begin
                    done_q <= 1'b0;
                    if (ph_cnt_q == 16'(ACCUM_CNT - 1)) begin
                        phase_q <= DSS_DISCHARGE; // RULE1 RULE3
                        ph_cnt_q <= 16'h0000;
                    end else begin
                        ph_cnt_q <= ph_cnt_q + 16'h0001;
                    end
                end
                DSS_DISCHARGE: begin
                    if (crossing || full) begin
                        phase_q <= DSS_INT_RESET; // RULE1 RULE23
                        ph_cnt_q <= 16'h0000;
                    end
                end
                DSS_INT_RESET: begin
                    if (ph_cnt_q == zi_len - 16'h0001) begin
                        phase_q <= DSS_OFFSET_NULL; // RULE1 RULE7
                        ph_cnt_q <= 16'h0000;
                    end else begin
                        ph_cnt_q <= ph_cnt_q + 16'h0001;
                    end
                end
                default: begin
                    phase_q <= DSS_OFFSET_NULL;
                    ph_cnt_q <= 16'h0000;
                end
            endcase
        end
    end

    // Cycle length counter, zero at the first count of accumulate.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cyc_q <= 16'h0000;
        end else if (tick) begin
            if (phase_q == DSS_OFFSET_NULL && done_q) begin
                cyc_q <= 16'h0000;
            end else if (phase_q == DSS_OFFSET_NULL &&
                         cyc_q == 16'(CYCLE_CNT - 1)) begin
                cyc_q <= 16'h0000; // RULE8
            end else begin
                cyc_q <= cyc_q + 16'h0001;
            end
        end
    end

    // Discharge counters, binary for limits and BCD for the reading.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            disch_q <= 16'h0000;
            bcd_cnt_q <= '0;
        end else if (tick) begin
            if (phase_q == DSS_ACCUM) begin
                disch_q <= 16'h0000;
                bcd_cnt_q <= '0;
            end else if (phase_q == DSS_DISCHARGE && !crossing && !full) begin
                disch_q <= disch_q + 16'h0001; // RULE5
                bcd_cnt_q <= dss_bcd_inc(bcd_cnt_q);
            end
        end
    end

    // Polarity flip-flop, caught on the last count of accumulate.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pol_q <= 1'b0;
        end else if (tick && phase_q == DSS_ACCUM &&
                     ph_cnt_q == 16'(ACCUM_CNT - 1)) begin
            pol_q <= comp_positive_i; // RULE4
        end
    end

    // Polarity pin becomes valid as discharge starts.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            polarity_o <= 1'b0;
        end else begin
            polarity_o <= pol_q; // RULE4
        end
    end

    // Busy spans accumulate and discharge up to the end of measurement.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else if (tick && phase_q == DSS_OFFSET_NULL &&
                     ((!done_q && cyc_q == 16'(CYCLE_CNT - 1) && run_hold_i) ||
                      (done_q && start_req_q &&
                       ph_cnt_q == 16'(`DSS_START_AZ_CNT - 1)))) begin
            busy_o <= 1'b1; // RULE19
        end else if (tick && phase_q == DSS_DISCHARGE && (crossing || full)) begin
            busy_o <= 1'b0; // RULE19
        end
    end

    // One-cycle events: measurement end, result load and discharge start.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meas_end_q <= 1'b0;
            load_q <= 1'b0;
            de_start_q <= 1'b0;
        end else begin
            meas_end_q <= tick && phase_q == DSS_DISCHARGE && (crossing || full);
            load_q <= meas_end_q; // RULE19
            de_start_q <= tick && phase_q == DSS_ACCUM &&
                          ph_cnt_q == 16'(ACCUM_CNT - 1);
        end
    end

    // Result latches load on the second clock after busy falls.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            result_q <= '0;
        end else if (load_q) begin
            result_q <= bcd_cnt_q; // RULE19
        end
    end

    // Overrange of the current cycle, used for the long integrator reset.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            over_cycle_q <= 1'b0;
        end else if (tick && phase_q == DSS_ACCUM) begin
            over_cycle_q <= 1'b0;
        end else if (tick && phase_q == DSS_DISCHARGE && full && !crossing) begin
            over_cycle_q <= 1'b1; // RULE23
        end
    end

    // Overrange pin: set at busy end, cleared when discharge starts again.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            overrange_o <= 1'b0;
        end else if (meas_end_q) begin
            overrange_o <= over_cycle_q; // RULE20
        end else if (de_start_q) begin
            overrange_o <= 1'b0; // RULE20
        end
    end

    // Underrange pin: set at busy end, cleared when accumulate starts.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            underrange_o <= 1'b0;
        end else if (meas_end_q) begin
            underrange_o <= !over_cycle_q &&
                            disch_q <= 16'(`DSS_UNDER_CNT); // RULE21
        end else if (tick && phase_q == DSS_ACCUM && ph_cnt_q == 16'h0000) begin
            underrange_o <= 1'b0; // RULE21
        end
    end

    // Analogue switch drive decoded from the phase.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            switch_o <= '0;
            phase_o <= DSS_OFFSET_NULL;
        end else begin
            phase_o <= phase_q;
            switch_o <= '0;
            case (phase_q)
                DSS_OFFSET_NULL: begin
                    switch_o.short_to_common <= 1'b1; // RULE2
                    switch_o.ref_cap_charge <= 1'b1; // RULE2
                    switch_o.offset_loop <= 1'b1; // RULE2
                end
                DSS_ACCUM: begin
                    switch_o.inputs_to_pins <= 1'b1; // RULE3
                end
                DSS_DISCHARGE: begin
                    switch_o.low_to_common <= 1'b1; // RULE5
                    switch_o.ref_cap_connect <= 1'b1; // RULE5
                    switch_o.ref_cap_invert <= pol_q; // RULE5
                end
                DSS_INT_RESET: begin
                    switch_o.low_to_common <= 1'b1; // RULE6
                    switch_o.reset_loop <= 1'b1; // RULE6
                end
                default: begin
                    switch_o.short_to_common <= 1'b1;
                end
            endcase
        end
    end

    // Digit scanning, BCD multiplexing and strobes.
    dss_digit_scan u_scan (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .restart_i(load_q),
        .resume_i(de_start_q),
        .over_i(overrange_o),
        .digits_i(result_q),
        .drive_o(digit_drive_o),
        .bcd_o(bcd_o),
        .strobe_n_o(strobe_n_o)
    );

endmodule // dss_sequencer

`default_nettype wire

// *** dv/dss_sequencer_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// Checks phase order, switch settings, flags and strobe timing at the ports.
module dss_sequencer_assertions
    import dss_pkg::*;
#(
    parameter int CYCLE_CNT = 40002,
    parameter int ACCUM_CNT = 10000,
    parameter int FULL_SCALE_CNT = 20000,
    parameter int ZI_OVER_CNT = 6200
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_hold_i,
    input wire logic comp_positive_i,
    input wire dss_pkg::dss_switch_t switch_o,
    input wire dss_pkg::dss_phase_t phase_o,
    input wire logic busy_o,
    input wire logic polarity_o,
    input wire logic overrange_o,
    input wire logic underrange_o,
    input wire logic [4:0] digit_drive_o,
    input wire logic [3:0] bcd_o,
    input wire logic strobe_n_o
);
    logic [15:0] zi_q;
    logic [3:0] strb_q;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // Counts clocks spent in integrator-reset.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || phase_o != DSS_INT_RESET) begin
            zi_q <= 16'h0000;
        end else begin
            zi_q <= zi_q + 16'h0001;
        end
    end

    // Counts strobes sent since the last measurement ended.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || $fell(busy_o)) begin
            strb_q <= 4'h0;
        end else if (!strobe_n_o) begin
            strb_q <= strb_q + 4'h1;
        end
    end

    a_phase_order: assert property (phase_o != $past(phase_o) |->
        4'(phase_o) == {$past(phase_o[2:0]), $past(phase_o[3])})
        else $error("phase left its fixed order");
    a_null_switches: assert property (!$past(rst_i) &&
        phase_o == DSS_OFFSET_NULL |-> switch_o == 8'he0)
        else $error("offset-null switches wrong");
    a_accum_switches: assert property (phase_o == DSS_ACCUM
        |-> switch_o == 8'h10) else $error("accumulate switches wrong");
    a_disch_switches: assert property (phase_o == DSS_DISCHARGE
        |-> switch_o.ref_cap_connect && !switch_o.offset_loop &&
        switch_o.ref_cap_invert == polarity_o)
        else $error("discharge switches wrong");
    a_zero_switches: assert property (phase_o == DSS_INT_RESET
        |-> switch_o.low_to_common && switch_o.reset_loop &&
        !switch_o.inputs_to_pins) else $error("integrator-reset switches wrong");
    a_zi_length: assert property (phase_o != DSS_INT_RESET &&
        $past(phase_o) == DSS_INT_RESET |-> (overrange_o ?
        zi_q == 16'(2 * ZI_OVER_CNT) : (zi_q >= 16'd200 && zi_q <= 16'd400)))
        else $error("integrator-reset length wrong");
    a_busy_in_accum: assert property ($rose(busy_o) |=>
        phase_o == DSS_ACCUM) else $error("busy rose outside accumulate");
    a_over_clear: assert property ($fell(overrange_o) |->
        phase_o == DSS_DISCHARGE) else $error("overrange cleared early");
    a_under_clear: assert property ($fell(underrange_o) |->
        phase_o == DSS_ACCUM) else $error("underrange cleared early");
    a_strobe_half: assert property ($fell(strobe_n_o) |=>
        $rose(strobe_n_o)) else $error("strobe longer than one clock");
    a_strobe_in_digit: assert property (!strobe_n_o |->
        $onehot(digit_drive_o) && $stable(digit_drive_o) && $stable(bcd_o))
        else $error("strobe outside a steady digit");
    a_strobe_count: assert property (strb_q <= 4'h5)
        else $error("more than five strobes for one result");

    c_strobe: cover property ($fell(strobe_n_o));
    c_over: cover property ($rose(overrange_o));
    c_under: cover property ($rose(underrange_o));
    c_busy: cover property ($rose(busy_o));
endmodule // dss_sequencer_assertions

bind dss_sequencer dss_sequencer_assertions #(.CYCLE_CNT(CYCLE_CNT),
    .ACCUM_CNT(ACCUM_CNT), .FULL_SCALE_CNT(FULL_SCALE_CNT),
    .ZI_OVER_CNT(ZI_OVER_CNT)) i_dss_sequencer_assertions (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_hold_i(run_hold_i),
    .comp_positive_i(comp_positive_i), .switch_o(switch_o),
    .phase_o(phase_o), .busy_o(busy_o), .polarity_o(polarity_o),
    .overrange_o(overrange_o), .underrange_o(underrange_o),
    .digit_drive_o(digit_drive_o), .bcd_o(bcd_o), .strobe_n_o(strobe_n_o));
`default_nettype wire

// *** dv/dss_latch_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// External latches that take one BCD digit on each strobe pulse.
module dss_latch_model (
    input wire logic clk_sys_i,
    input wire logic clr_i,
    input wire logic strobe_n_i,
    input wire logic [4:0] drive_i,
    input wire logic [3:0] bcd_i,
    output dss_pkg::dss_digits_t digits_o,
    output logic [3:0] n_strobe_o,
    output logic order_bad_o
);
    import dss_pkg::*;
    logic [4:0] last_q;

    // Captures the active digit and flags a strobe out of scan order.
    always @(posedge clk_sys_i) begin
        if (clr_i) begin
            n_strobe_o <= 4'h0;
            order_bad_o <= 1'b0;
            last_q <= 5'h01;
        end else if (strobe_n_i === 1'b0) begin
            for (int i = 0; i < 5; i++) begin
                if (drive_i[i]) begin
                    digits_o[i] <= bcd_i;
                end
            end
            if (drive_i !== {last_q[0], last_q[4:1]}) begin
                order_bad_o <= 1'b1;
            end
            last_q <= drive_i;
            n_strobe_o <= n_strobe_o + 4'h1;
        end
    end
endmodule // dss_latch_model
`default_nettype wire

// *** dv/dss_sequencer_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module dss_sequencer_tb_top;
    import dss_pkg::*;
    localparam int CYC = 200;
    localparam int FS = 20;
    logic clk_sys_i, rst_i, run_hold_i, comp_positive_i, clr, sign, busy_q;
    dss_switch_t switch_o;
    dss_phase_t phase_o;
    logic busy_o, polarity_o, overrange_o, underrange_o, strobe_n_o;
    logic [4:0] digit_drive_o, drv_q;
    logic [3:0] bcd_o, n_strb;
    dss_digits_t seen;
    logic order_bad, top_q;
    logic [2:0] fall_q;
    logic [31:0] lfsr;
    int failures, n_tests, cycles, drv_t, dis_n, cross_at, n_rise, t_rise;

    dss_sequencer #(.CYCLE_CNT(CYC), .ACCUM_CNT(10), .FULL_SCALE_CNT(FS),
        .ZI_OVER_CNT(30)) i_dss_sequencer (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .run_hold_i(run_hold_i),
        .comp_positive_i(comp_positive_i), .switch_o(switch_o),
        .phase_o(phase_o), .busy_o(busy_o), .polarity_o(polarity_o),
        .overrange_o(overrange_o), .underrange_o(underrange_o),
        .digit_drive_o(digit_drive_o), .bcd_o(bcd_o), .strobe_n_o(strobe_n_o));
    dss_latch_model i_dss_latch_model (.clk_sys_i(clk_sys_i), .clr_i(clr),
        .strobe_n_i(strobe_n_o), .drive_i(digit_drive_o), .bcd_i(bcd_o),
        .digits_o(seen), .n_strobe_o(n_strb), .order_bad_o(order_bad));

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Timing figures may land one clock either side of the ideal point.
    task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got + 1 < exp || got > exp + 1) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wait_rise(input int k);
        for (int w = 0; w < 5000 && n_rise < k; w++) @(posedge clk_sys_i);
    endtask

    // One held conversion: start pulse, optional ignored pulse, then result.
    task automatic single(input int n, input logic s, input logic dbl);
        int r0, t0;
        logic [31:0] got;
        cross_at = n;
        sign = s;
        r0 = n_rise;
        t0 = cycles;
        clr <= 1'b1;
        run_hold_i <= 1'b1;
        repeat (32) @(posedge clk_sys_i);
        clr <= 1'b0;
        run_hold_i <= 1'b0;
        wait_rise(r0 + 1);
        chk(32'(t_rise - t0 <= 20006), 1);
        if (dbl) begin
            run_hold_i <= 1'b1;
            repeat (32) @(posedge clk_sys_i);
            run_hold_i <= 1'b0;
        end
        for (int w = 0; w < 3000 && n_strb < 5; w++) @(posedge clk_sys_i);
        got = seen[0] + 10 * seen[1] + 100 * seen[2] + 1000 * seen[3];
        chk(32'(polarity_o), 32'(s));
        chk(32'(overrange_o), 32'(n >= FS));
        chk(32'(underrange_o), 32'(n < FS));
        if (n < FS) chk_near(got, 32'(n));
        chk(32'(order_bad), 0);
        repeat (900) @(posedge clk_sys_i);
        chk(32'(n_strb), 5);
        chk(32'(n_rise - r0), 1);
        if (n >= FS) chk(32'(digit_drive_o), 0);
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Comparator follows the input sign until the chosen crossing count.
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        dis_n <= (phase_o == DSS_DISCHARGE) ? dis_n + 1 : 0;
        comp_positive_i <= (phase_o == DSS_DISCHARGE &&
            dis_n >= 2 * cross_at) ? !sign : sign;
        busy_q <= busy_o;
        if (busy_o === 1'b1 && busy_q === 1'b0) begin
            n_rise <= n_rise + 1;
            t_rise <= cycles;
        end
        if (cycles > 40000) begin
            failures++;
            test_done();
        end
    end

    // Measures each digit length and where its strobe falls.
    always @(posedge clk_sys_i) begin
        fall_q <= {fall_q[1:0], busy_q && !busy_o};
        if (!rst_i && (fall_q[2] || digit_drive_o !== drv_q)) begin
            if (!fall_q[2] && drv_q != 5'h00 && digit_drive_o != 5'h00) begin
                chk(32'(cycles - drv_t), top_q ? 402 : 400);
            end
            drv_t <= cycles;
            top_q <= fall_q[2];
        end
        if (!rst_i && strobe_n_o === 1'b0) begin
            chk_near(32'(cycles - drv_t), 201);
        end
        drv_q <= digit_drive_o;
    end

    initial begin
        int r0, t0;
        rst_i = 1'b1;
        clr = 1'b1;
        {run_hold_i, comp_positive_i, sign, busy_q, drv_q, top_q} = '0;
        lfsr = 32'h4bef9cb2;
        {failures, n_tests, cycles, drv_t, dis_n, n_rise, t_rise} = '0;
        cross_at = 5;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        chk(32'(strobe_n_o), 1);
        chk(32'(phase_o), 32'(DSS_OFFSET_NULL));
        repeat (220) @(posedge clk_sys_i);
        for (int i = 0; i < 6; i++) begin
            lfsr = nxt(lfsr);
            single(i == 0 ? 1 : (i == 1 ? FS - 1 : 1 + int'(lfsr % 19)),
                lfsr[7], i[0]);
        end
        single(1000, 1'b1, 1'b0);
        single(3, 1'b0, 1'b0);
        run_hold_i <= 1'b1;
        r0 = n_rise;
        wait_rise(r0 + 1);
        t0 = t_rise;
        wait_rise(r0 + 2);
        chk(32'(t_rise - t0), 32'(2 * CYC));
        run_hold_i <= 1'b0;
        r0 = n_rise;
        repeat (1500) @(posedge clk_sys_i);
        chk(32'(n_rise - r0), 0);
        test_done();
    end
endmodule // dss_sequencer_tb_top
`default_nettype wire
